// *** rcec_pkg.sv ***
/*
 rcec_pkg: constants for the reset and clock-enable controller.
 assumes a single 20 MHz core clock; all times are converted here.
*/
package rcec_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_MHZ = CLK_HZ / 1_000_000;
    // reset pin: reset must follow pin assertion within this window
    localparam int RST_MIN_US = 1500;
    localparam int RST_MAX_US = 4000;
    localparam int RST_MIN_CYC = RST_MIN_US * CLK_MHZ;
    localparam int RST_MAX_CYC = RST_MAX_US * CLK_MHZ;
    // chosen reset delay, inside the window
    localparam int RST_DELAY_US = 2000;
    localparam int RST_DELAY_CYC = RST_DELAY_US * CLK_MHZ;
    // glitch filter on the reset pin, least time so rounded up
    localparam int GLITCH_NS = 1000;
    localparam int GLITCH_CYC = (GLITCH_NS * CLK_MHZ + 999) / 1000;
    // serial receive held low this long counts as a break
    localparam int BREAK_US = 100;
    localparam int BREAK_CYC = BREAK_US * CLK_MHZ;
    // internal reset is stretched this many cycles after the last source
    localparam int HOLD_CYC = 16;
    // general-purpose lines
    localparam int NGIO = 11;
    localparam int GIO_OR_OUT = 2;
    localparam int GIO_HOST_EN = 3;
    // other pads: indices 0..3 are outputs, 4..6 inputs
    localparam int NPAD = 7;
    localparam int NPAD_OUT = 4;
    localparam int PAD_UART_TX = 0;
    localparam int PAD_UART_RTS = 1;
    localparam int PAD_VOICE_OUT = 2;
    localparam int PAD_DBG_MISO = 3;
    localparam int PAD_DBG_SEL = 4;
    localparam int PAD_RESET_PIN = 5;
    localparam int PAD_OTHER_IN = 6;
    localparam logic [NPAD-1:0] PAD_PU_MASK = 7'h33;
    localparam logic [NPAD-1:0] PAD_PD_MASK = 7'h4C;
    // crystal frequency assumed after reset
    localparam int XTAL_W = 4;
    localparam logic [XTAL_W-1:0] XTAL_CODE_40M = 4'h0;
    localparam int WD_W = 16;
    typedef enum {RCEC_RUN, RCEC_RESET, RCEC_HOLD} rcec_state_type;
endpackage

// *** rcec_filt_if.sv ***
/*
 rcec_filt_if: reset pin path between the controller and its pin filter.
 assumes the pin is synchronous to clk.
*/
`timescale 1ns/10ps
interface rcec_filt_if;
    logic pin_n;
    logic level;
    logic pin_req;
    modport flt(input pin_n, output level, output pin_req);
    modport ctl(output pin_n, input level, input pin_req);
endinterface // rcec_filt_if

// *** rcec_pin_filter.sv ***
/*
 rcec_pin_filter: glitch filter and assertion delay for the reset pin.
 assumes a synchronous pin and an active-low asynchronous reset.
*/
`timescale 1ns/10ps
module rcec_pin_filter #(
    parameter int FILT = rcec_pkg::GLITCH_CYC,
    parameter int DELAY = rcec_pkg::RST_DELAY_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    rcec_filt_if.flt fl
);
    localparam int FW = $clog2(FILT + 1);
    localparam int DW = $clog2(DELAY + 1);
    logic [FW-1:0] fcnt;
    logic [DW-1:0] dcnt;

    // level flips only after FILT steady cycles of the other value
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fcnt <= '0;
            fl.level <= 1'b1;
        end else if (fl.pin_n == fl.level) begin
            fcnt <= '0;
        end else if (fcnt == FW'(FILT - 1)) begin
            fl.level <= fl.pin_n;
            fcnt <= '0;
        end else begin
            fcnt <= fcnt + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dcnt <= '0;
            fl.pin_req <= 1'b0;
        end else if (fl.level) begin
            dcnt <= '0;
            fl.pin_req <= 1'b0;
        end else if (dcnt == DW'(DELAY - 1)) begin
            fl.pin_req <= 1'b1;
        end else begin
            dcnt <= dcnt + 1'b1;
        end
    end
endmodule // rcec_pin_filter

// *** rcec_ctrl.sv ***
/*
 rcec_ctrl: chip reset combiner, pad safe states and clock-enable OR.
 assumes one 20 MHz clock, synchronous inputs, rstn acting as power-on reset.
*/
// Operation
// - reset comes from pin, power-on, serial break or watchdog expiry
// - reset pin is active low and glitch filtered
// - pin reset happens 1.5 ms to 4.0 ms after pin assertion
// - in reset all pads are inputs or tri-stated; general lines pulled down
// - serial transmit and request-to-send tri-stated with weak pull-ups in reset
// - voice and debug serial outputs tri-stated with weak pull-downs in reset
// - debug select and reset pin pull up; other inputs pull down
// - after any reset assume 40 MHz crystal input
// - oscillator free-runs without crystal clock; radio waits for it
// - line 2 outputs OR of host enable on line 3 and oscillator enable
// - line 2 stays tri-stated until software configures it
// - warm reset keeps persistent store, resets hardware, reattaches USB
// - warm reset keeps baud rate and RAM contents available
// - cold reset from power, firmware fault or pin discards them
// - deep sleep puts the regulator into low-power mode
// - without core supply every input has a weak pull-down
`timescale 1ns/10ps
module rcec_ctrl #(
    parameter int RST_DELAY = rcec_pkg::RST_DELAY_CYC,
    parameter int FILT = rcec_pkg::GLITCH_CYC,
    parameter int BREAK_LEN = rcec_pkg::BREAK_CYC,
    parameter int WDW = rcec_pkg::WD_W
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic chip_reset_in_n,
    input wire logic uart_rx_line,
    input wire logic wdog_enable,
    input wire logic wdog_kick,
    input wire logic [WDW-1:0] wdog_period,
    input wire logic warm_reset_req,
    input wire logic fw_fault_reset,
    input wire logic core_supply_ok,
    input wire logic deep_sleep,
    input wire logic crystal_clock_present,
    input wire logic xtal_cfg_we,
    input wire logic [rcec_pkg::XTAL_W-1:0] xtal_cfg_code,
    input wire logic clk_or_config,
    input wire logic osc_enable_int,
    input wire logic [rcec_pkg::NGIO-1:0] general_io_line_in,
    input wire logic [rcec_pkg::NGIO-1:0] gio_drive,
    input wire logic [rcec_pkg::NGIO-1:0] gio_data,
    input wire logic [rcec_pkg::NGIO-1:0] gio_pull_cfg,
    input wire logic [rcec_pkg::NPAD_OUT-1:0] pad_drive,
    input wire logic [rcec_pkg::NPAD_OUT-1:0] pad_data,
    output logic core_reset_n,
    output logic reset_was_cold,
    output logic retain_ram_baud,
    output logic erase_persistent_store_area,
    output logic usb_detach,
    output logic [rcec_pkg::XTAL_W-1:0] xtal_freq_code,
    output logic osc_free_run,
    output logic radio_enable,
    output logic regulator_low_power,
    output logic [rcec_pkg::NGIO-1:0] general_io_line_out,
    output logic [rcec_pkg::NGIO-1:0] general_io_line_oe_n,
    output logic [rcec_pkg::NGIO-1:0] gio_pull_down,
    output logic [rcec_pkg::NPAD_OUT-1:0] pad_out,
    output logic [rcec_pkg::NPAD_OUT-1:0] pad_oe_n,
    output logic [rcec_pkg::NPAD-1:0] pad_pull_up,
    output logic [rcec_pkg::NPAD-1:0] pad_pull_down
);
    localparam int BW = $clog2(BREAK_LEN + 1);
    localparam int HW = $clog2(rcec_pkg::HOLD_CYC + 1);
    localparam int PW = $clog2(RST_DELAY + FILT + 64);
    localparam int PIN_MIN = RST_DELAY;
    localparam int PIN_MAX = RST_DELAY + FILT + 4;
    rcec_filt_if fi();
    assign fi.pin_n = chip_reset_in_n;
    rcec_pin_filter #(.FILT(FILT), .DELAY(RST_DELAY)) u_filt (
        .clk(clk),
        .rstn(rstn),
        .fl(fi.flt)
    );
    rcec_pkg::rcec_state_type state;
    rcec_pkg::rcec_state_type next_state;
    logic [HW-1:0] hold_cnt;
    logic [BW-1:0] brk_cnt;
    logic brk_req;
    logic [WDW-1:0] wd_cnt;
    logic wd_exp;
    logic level_req;
    logic pulse_req;
    logic next_run;
    logic cold_src;
    logic next_cold;
    logic or_cfg;
    logic supply_ok;
    // level sources hold the chip in reset; pulse sources only start it
    assign level_req = fi.pin_req | brk_req | wd_exp;
    assign pulse_req = warm_reset_req | fw_fault_reset;
    assign cold_src = fi.pin_req | fw_fault_reset;
    assign supply_ok = core_supply_ok;
    // serial break: receive line held low for BREAK_LEN cycles
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            brk_cnt <= '0;
            brk_req <= 1'b0;
        end else if (uart_rx_line) begin
            brk_cnt <= '0;
            brk_req <= 1'b0;
        end else if (brk_cnt == BW'(BREAK_LEN - 1)) begin
            brk_req <= 1'b1;
        end else begin
            brk_cnt <= brk_cnt + 1'b1;
        end
    end
    // watchdog: reloads on kick, expiry holds until reset clears it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wd_cnt <= '0;
            wd_exp <= 1'b0;
        end else if (!core_reset_n || !wdog_enable || wdog_kick) begin
            wd_cnt <= wdog_period;
            wd_exp <= 1'b0;
        end else if (wd_cnt == '0) begin
            wd_exp <= 1'b1;
        end else begin
            wd_cnt <= wd_cnt - 1'b1;
        end
    end
    always_comb begin
        next_state = state;
        case (state)
            rcec_pkg::RCEC_RUN: begin
                if (level_req || pulse_req) begin
                    next_state = rcec_pkg::RCEC_RESET;
                end
            end
            rcec_pkg::RCEC_RESET: begin
                if (!level_req) begin
                    next_state = rcec_pkg::RCEC_HOLD;
                end
            end
            rcec_pkg::RCEC_HOLD: begin
                if (level_req || pulse_req) begin
                    next_state = rcec_pkg::RCEC_RESET;
                end else if (hold_cnt == HW'(rcec_pkg::HOLD_CYC - 1)) begin
                    next_state = rcec_pkg::RCEC_RUN;
                end
            end
            default: begin
                next_state = rcec_pkg::RCEC_RESET;
            end
        endcase
    end
    assign next_run = (next_state == rcec_pkg::RCEC_RUN);
    // power-on reset leaves the chip in reset and marks it cold
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= rcec_pkg::RCEC_RESET;
            hold_cnt <= '0;
            core_reset_n <= 1'b0;
        end else begin
            state <= next_state;
            hold_cnt <= (state == rcec_pkg::RCEC_HOLD) ? hold_cnt + 1'b1 : '0;
            core_reset_n <= next_run;
        end
    end
    // a cold cause anywhere in the reset episode makes it cold
    always_comb begin
        next_cold = reset_was_cold;
        if (state == rcec_pkg::RCEC_RUN && (level_req || pulse_req)) begin
            next_cold = cold_src;
        end else if (state != rcec_pkg::RCEC_RUN && cold_src) begin
            next_cold = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reset_was_cold <= 1'b1;
            retain_ram_baud <= 1'b0;
            erase_persistent_store_area <= 1'b1;
            usb_detach <= 1'b1;
        end else begin
            reset_was_cold <= next_cold;
            retain_ram_baud <= !next_cold;
            erase_persistent_store_area <= !next_run && next_cold;
            usb_detach <= !next_run;
        end
    end
    // clock assumptions; radio links drop whenever reset is held
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            xtal_freq_code <= rcec_pkg::XTAL_CODE_40M;
            osc_free_run <= 1'b1;
            radio_enable <= 1'b0;
            regulator_low_power <= 1'b0;
        end else begin
            if (!next_run) begin
                xtal_freq_code <= rcec_pkg::XTAL_CODE_40M;
            end else if (xtal_cfg_we) begin
                xtal_freq_code <= xtal_cfg_code;
            end
            osc_free_run <= !crystal_clock_present;
            radio_enable <= next_run && crystal_clock_present;
            regulator_low_power <= next_run && deep_sleep;
        end
    end
    // OR function is off until software sets it, and again after any reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            or_cfg <= 1'b0;
        end else if (!next_run) begin
            or_cfg <= 1'b0;
        end else if (clk_or_config) begin
            or_cfg <= 1'b1;
        end
    end
    // general lines: the reset image wins over any core request
    for (genvar i = 0; i < rcec_pkg::NGIO; i++) begin : g_gio
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                general_io_line_out[i] <= 1'b0;
                general_io_line_oe_n[i] <= 1'b1;
                gio_pull_down[i] <= 1'b1;
            end else if (!next_run || !supply_ok) begin
                general_io_line_out[i] <= 1'b0;
                general_io_line_oe_n[i] <= 1'b1;
                gio_pull_down[i] <= 1'b1;
            end else if (i == rcec_pkg::GIO_OR_OUT) begin
                general_io_line_out[i] <= general_io_line_in[rcec_pkg::GIO_HOST_EN] | osc_enable_int;
                general_io_line_oe_n[i] <= !or_cfg;
                gio_pull_down[i] <= gio_pull_cfg[i];
            end else if (i == rcec_pkg::GIO_HOST_EN && or_cfg) begin
                general_io_line_out[i] <= 1'b0;
                general_io_line_oe_n[i] <= 1'b1;
                gio_pull_down[i] <= gio_pull_cfg[i];
            end else begin
                general_io_line_out[i] <= gio_data[i];
                general_io_line_oe_n[i] <= !gio_drive[i];
                gio_pull_down[i] <= gio_pull_cfg[i];
            end
        end
    end
    // other pads keep their weak pulls in run too; only the drivers change
    for (genvar p = 0; p < rcec_pkg::NPAD; p++) begin : g_pad
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                pad_pull_up[p] <= rcec_pkg::PAD_PU_MASK[p];
                pad_pull_down[p] <= rcec_pkg::PAD_PD_MASK[p];
            end else if (!supply_ok) begin
                pad_pull_up[p] <= 1'b0;
                pad_pull_down[p] <= 1'b1;
            end else begin
                pad_pull_up[p] <= rcec_pkg::PAD_PU_MASK[p];
                pad_pull_down[p] <= rcec_pkg::PAD_PD_MASK[p];
            end
        end
        if (p < rcec_pkg::NPAD_OUT) begin : g_out
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    pad_out[p] <= 1'b0;
                    pad_oe_n[p] <= 1'b1;
                end else if (!next_run || !supply_ok) begin
                    pad_out[p] <= 1'b0;
                    pad_oe_n[p] <= 1'b1;
                end else begin
                    pad_out[p] <= pad_data[p];
                    pad_oe_n[p] <= !pad_drive[p];
                end
            end
        end
    end

    // helper: consecutive cycles the raw pin has been low
    logic [PW-1:0] pin_low_cnt;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_low_cnt <= '0;
        end else if (chip_reset_in_n) begin
            pin_low_cnt <= '0;
        end else if (pin_low_cnt != PW'(PIN_MAX + 1)) begin
            pin_low_cnt <= pin_low_cnt + 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    chk_pin_delay_min: assert property (
        $rose(fi.pin_req) |-> pin_low_cnt >= PW'(PIN_MIN))
        else $error("pin reset request came too early");
    chk_pin_delay_max: assert property (
        pin_low_cnt > PW'(PIN_MAX) |-> fi.pin_req ##1 !core_reset_n)
        else $error("pin reset not taken in time");
    chk_source_enters: assert property (
        (fi.pin_req || brk_req || wd_exp) |=> !core_reset_n)
        else $error("reset source did not hold internal reset");
    chk_release_clean: assert property (
        $rose(core_reset_n) |-> $past(state) == rcec_pkg::RCEC_HOLD && !$past(level_req))
        else $error("reset released while a source was active");
    chk_wdog_expiry: assert property (
        core_reset_n && wdog_enable && !wdog_kick && wd_cnt == '0 |-> ##2 !core_reset_n)
        else $error("watchdog expiry did not reset");
    chk_pins_safe: assert property (
        !core_reset_n |-> &general_io_line_oe_n && &pad_oe_n && &gio_pull_down)
        else $error("pad driven during reset");
    chk_pad_pulls: assert property (
        !core_reset_n && $past(supply_ok) |-> pad_pull_up == rcec_pkg::PAD_PU_MASK
            && pad_pull_down == rcec_pkg::PAD_PD_MASK)
        else $error("wrong pad pulls in reset");
    chk_supply_pd: assert property (
        !supply_ok |=> &pad_pull_down && pad_pull_up == '0 && &gio_pull_down)
        else $error("inputs not pulled down without supply");
    chk_xtal_default: assert property (
        !core_reset_n |-> xtal_freq_code == rcec_pkg::XTAL_CODE_40M)
        else $error("crystal code not 40 MHz in reset");
    chk_or_output: assert property (
        or_cfg && next_run && supply_ok |=> !general_io_line_oe_n[rcec_pkg::GIO_OR_OUT]
            && general_io_line_out[rcec_pkg::GIO_OR_OUT]
            == $past(general_io_line_in[rcec_pkg::GIO_HOST_EN] | osc_enable_int))
        else $error("clock-enable OR output wrong");
    chk_or_tristate: assert property (
        !or_cfg |=> general_io_line_oe_n[rcec_pkg::GIO_OR_OUT])
        else $error("OR output driven before configuration");
    chk_cold_pin: assert property (
        $rose(fi.pin_req) |=> reset_was_cold && !retain_ram_baud)
        else $error("pin reset not cold");
    chk_regulator: assert property (
        regulator_low_power |-> $past(deep_sleep) && core_reset_n)
        else $error("regulator low power without deep sleep");
    chk_radio_clock: assert property (
        radio_enable |-> $past(crystal_clock_present) && !osc_free_run)
        else $error("radio enabled without crystal clock");

    cov_pin_reset: cover property ($rose(fi.pin_req));
    cov_break_reset: cover property ($rose(brk_req) ##1 !core_reset_n);
    cov_wdog_reset: cover property ($rose(wd_exp));
    cov_warm_release: cover property (!reset_was_cold && $rose(core_reset_n));
endmodule // rcec_ctrl

// *** rcec_host_model.sv ***
/*
 rcec_host_model: host controller and external reset driver beside the controller.
 assumes the testbench calls its tasks; lines change only at the falling clock edge.
*/
`timescale 1ns/10ps
module rcec_host_model (
    input wire logic clk,
    output logic reset_pin_n,
    output logic host_clk_en
);
    initial begin
        reset_pin_n = 1'h1;
        host_clk_en = 1'h0;
    end
    // hold length is the caller's: short lows are wanted on purpose for the glitch case
    task automatic press_reset(input int cycles);
        @(negedge clk);
        reset_pin_n <= 1'h0;
        repeat (cycles) @(negedge clk);
        reset_pin_n <= 1'h1;
    endtask
    task automatic set_clk_en(input logic en);
        @(negedge clk);
        host_clk_en <= en;
    endtask
endmodule // rcec_host_model

// *** test_reset_and_clock_enable_control.sv ***
/*
 test_reset_and_clock_enable_control: self-checking bench for rcec_ctrl.
 assumes shortened delay, filter and break parameters; host model drives pin and line 3.
*/
`timescale 1ns/10ps
module test_reset_and_clock_enable_control;
    localparam int RD = 50;
    localparam int FL = 4;
    localparam int BL = 10;
    logic clk = 1'h0;
    logic rstn = 1'h0;
    logic rx = 1'h1, wd_en = 1'h0, wd_kick = 1'h0, warm = 1'h0, fault = 1'h0, sup = 1'h1;
    logic sleep = 1'h0, xpres = 1'h1, xwe = 1'h0, or_cfg = 1'h0, osc_en = 1'h0;
    logic [15:0] wd_per = 16'h0002;
    logic [3:0] xcfg = 4'h5;
    logic [10:0] gin = 11'h000, gdrv = 11'h7FB, gdat = 11'h555, gpull = 11'h7FF;
    logic [3:0] pdrv = 4'hF, pdat = 4'hA;
    logic core_reset_n, cold, retain, erase, usb, free_run, radio, reg_lp;
    logic [3:0] xtal, p_out, p_oe_n;
    logic [10:0] g_out, g_oe_n, g_pd;
    logic [6:0] p_pu, p_pd;
    wire pin_n, host_en;
    wire [10:0] gio_in = {gin[10:4], host_en, gin[2:0]};
    int err_count = 0;
    int n_tests = 0;
    always #25 clk = ~clk;
    rcec_host_model i_host (.clk(clk), .reset_pin_n(pin_n), .host_clk_en(host_en));
    rcec_ctrl #(.RST_DELAY(RD), .FILT(FL), .BREAK_LEN(BL), .WDW(16)) i_dut (
        .clk(clk), .rstn(rstn), .chip_reset_in_n(pin_n), .uart_rx_line(rx), .wdog_enable(wd_en),
        .wdog_kick(wd_kick), .wdog_period(wd_per), .warm_reset_req(warm), .fw_fault_reset(fault),
        .core_supply_ok(sup), .deep_sleep(sleep), .crystal_clock_present(xpres), .xtal_cfg_we(xwe),
        .xtal_cfg_code(xcfg), .clk_or_config(or_cfg), .osc_enable_int(osc_en),
        .general_io_line_in(gio_in), .gio_drive(gdrv), .gio_data(gdat), .gio_pull_cfg(gpull),
        .pad_drive(pdrv), .pad_data(pdat), .core_reset_n(core_reset_n), .reset_was_cold(cold),
        .retain_ram_baud(retain), .erase_persistent_store_area(erase), .usb_detach(usb), .xtal_freq_code(xtal),
        .osc_free_run(free_run), .radio_enable(radio), .regulator_low_power(reg_lp),
        .general_io_line_out(g_out), .general_io_line_oe_n(g_oe_n), .gio_pull_down(g_pd),
        .pad_out(p_out), .pad_oe_n(p_oe_n), .pad_pull_up(p_pu), .pad_pull_down(p_pd));
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask
    task automatic wait_core(input logic lvl, input int maxc, output int n);
        n = 0;
        while (core_reset_n !== lvl && n < maxc) begin
            @(negedge clk);
            n++;
        end
        if (core_reset_n !== lvl) begin
            $display("Error core_reset_n expected %h seen %h", lvl, core_reset_n);
            err_count++;
            close_out;
        end
    endtask
    // pads in reset: drive requests are held high on purpose, so tri-state must win
    task automatic chk_pads;
        chk("gio_oe_n", 16'h07FF, g_oe_n);
        chk("gio_pull_down", 16'h07FF, g_pd);
        chk("pad_oe_n", 16'h000F, p_oe_n);
        chk("pad_pull_up", 16'h0033, p_pu);
        chk("pad_pull_down", 16'h004C, p_pd);
        chk("xtal_code", 16'h0000, xtal);
    endtask
    task automatic t_pin;
        int n;
        n = 0;
        fork
            i_host.press_reset(FL - 1);
            repeat (FL + RD + 10) begin
                @(negedge clk);
                if (core_reset_n !== 1'h1) n++;
            end
        join
        chk("glitch_resets", 16'h0000, n);
        fork
            i_host.press_reset(FL + RD + 20);
            wait_core(1'h0, FL + RD + 10, n);
        join_any
        chk("pin_delay_in_window", 16'h0001, n >= FL + RD && n <= FL + RD + 4);
        repeat (2) @(negedge clk);
        chk("pin_cold", 16'h0001, cold);
        chk("pin_erase", 16'h0001, erase);
        chk("pin_usb_detach", 16'h0001, usb);
        chk_pads();
        wait_core(1'h1, 100, n);
    endtask
    task automatic t_break;
        int n;
        rx <= 1'h0;
        repeat (BL + 2) @(negedge clk);
        rx <= 1'h1;
        wait_core(1'h0, 4, n);
        repeat (2) @(negedge clk);
        chk("break_cold", 16'h0000, cold);
        chk("break_retain", 16'h0001, retain);
        chk("break_erase", 16'h0000, erase);
        chk("break_usb_detach", 16'h0001, usb);
        wait_core(1'h1, 100, n);
    endtask
    task automatic t_wdog;
        int n;
        n = 0;
        wd_en <= 1'h1;
        wd_kick <= 1'h1;
        repeat (20) begin
            @(negedge clk);
            if (core_reset_n !== 1'h1) n++;
        end
        chk("kicked_wdog_resets", 16'h0000, n);
        wd_kick <= 1'h0;
        wait_core(1'h0, 10, n);
        wd_en <= 1'h0;
        chk("wdog_expiry_time", 16'h0001, n >= 3 && n <= 6);
        @(negedge clk);
        chk("wdog_cold", 16'h0000, cold);
        wait_core(1'h1, 100, n);
    endtask
    task automatic t_or;
        @(negedge clk);
        chk("or_line_unconfigured", 16'h0001, g_oe_n[2]);
        or_cfg <= 1'h1;
        @(negedge clk);
        or_cfg <= 1'h0;
        for (int k = 0; k < 4; k++) begin
            i_host.set_clk_en(k[1]);
            osc_en <= k[0];
            repeat (2) @(negedge clk);
            chk("or_line_value", k[1] | k[0], g_out[2]);
            chk("or_line_driven", 16'h0000, g_oe_n[2]);
        end
        chk("host_en_line_input", 16'h0001, g_oe_n[3]);
    endtask
    // warm request then firmware fault; each must restore the 40 MHz code and drop line 2
    task automatic t_pulses;
        int n;
        for (int i = 0; i < 2; i++) begin
            xwe <= 1'h1;
            @(negedge clk);
            xwe <= 1'h0;
            @(negedge clk);
            chk("xtal_written", 16'h0005, xtal);
            if (i == 0) warm <= 1'h1;
            else fault <= 1'h1;
            @(negedge clk);
            warm <= 1'h0;
            fault <= 1'h0;
            wait_core(1'h0, 3, n);
            @(negedge clk);
            chk("pulse_cold", i, cold);
            chk_pads();
            wait_core(1'h1, 100, n);
            @(negedge clk);
            chk("or_line_after_reset", 16'h0001, g_oe_n[2]);
        end
    endtask
    task automatic t_misc;
        xpres <= 1'h0;
        sleep <= 1'h1;
        repeat (3) @(negedge clk);
        chk("free_run_no_xtal", 16'h0001, free_run);
        chk("radio_no_xtal", 16'h0000, radio);
        chk("regulator_sleep", 16'h0001, reg_lp);
        xpres <= 1'h1;
        sleep <= 1'h0;
        repeat (3) @(negedge clk);
        chk("radio_with_xtal", 16'h0001, radio);
        chk("regulator_awake", 16'h0000, reg_lp);
        chk("gio_drive_run", 16'h0000, g_oe_n[0]);
        chk("gio_out_run", 16'h0555, g_out);
        chk("gio_oe_n_run", 16'h0004, g_oe_n);
        chk("pad_out_run", 16'h000A, p_out);
        chk("pad_oe_n_run", 16'h0000, p_oe_n);
    endtask
    task automatic t_supply;
        int n;
        sup <= 1'h0;
        repeat (2) @(negedge clk);
        chk("nosupply_pull_up", 16'h0000, p_pu);
        chk("nosupply_pull_down", 16'h007F, p_pd);
        chk("nosupply_gio_pull", 16'h07FF, g_pd);
        sup <= 1'h1;
        wait_core(1'h1, 100, n);
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        $display("Error run_length limit reached");
        err_count++;
        close_out();
    end
    initial begin
        int n;
        repeat (20) @(negedge clk);
        chk("core_in_reset", 16'h0000, core_reset_n);
        chk_pads();
        rstn <= 1'h1;
        wait_core(1'h1, 40, n);
        t_pin();
        t_break();
        t_wdog();
        t_or();
        t_pulses();
        t_misc();
        t_supply();
        close_out();
    end
endmodule // test_reset_and_clock_enable_control
